/* hdl/ppl_pkg.sv */
package ppl_pkg;
  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  localparam int CTRL_W = 8;
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_AUTOLF = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELECT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------
  // status register layout
  // ----------------------------------------
  localparam int STAT_ERROR = 3;
  localparam int STAT_SELECTED = 4;
  localparam int STAT_PAPER_OUT = 5;
  localparam int STAT_ACK = 6;
  localparam int STAT_BUSY = 7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int SYNC_STAGES = 3;
endpackage

/* hdl/ppl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module ppl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1, s2, s3, next_q;
  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s3[i];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

/* hdl/ppl_port.sv */
// What this block does
// - select-out pin is the inverse of control bit 3.
// - initialize pin follows control bit 2 directly.
// - auto line-feed pin is the inverse of control bit 1.
// - data strobe pin is the inverse of control bit 0.
// - error input readable at status bit 3.
// - data bus released whenever the port is deselected.
`timescale 1ns/1ps
`default_nettype none
module ppl_port (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic PORT_SELECT,
  input wire logic DIR_INPUT,
  input wire logic CTRL_WE,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic DATA_WE,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] CTRL_RDATA,
  output logic [7:0] STATUS_RDATA,
  output logic [7:0] DATA_RDATA,
  output logic PRINTER_SELECT_OUT_N,
  output logic INIT_N,
  output logic AUTO_LINEFEED_N,
  output logic DATA_STROBE_N,
  input wire logic PRINTER_SELECTED_IN,
  input wire logic PAPER_OUT_IN,
  input wire logic BUSY_IN,
  input wire logic ACK_N_IN,
  input wire logic ERROR_N_IN,
  input wire logic [7:0] PRINTER_DATA_BUS_I,
  output logic [7:0] PRINTER_DATA_BUS_O,
  output logic [7:0] PRINTER_DATA_BUS_OE
);
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [7:0] ctrl, next_ctrl, data_out, next_data_out, data_in, next_data_in;
  logic [7:0] status, next_status;
  logic [4:0] stat_sync;
  logic [7:0] bus_sync;
  logic drive_bus;

  ppl_sync #(.W(5)) u_stat_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .d({BUSY_IN, ACK_N_IN, PAPER_OUT_IN, PRINTER_SELECTED_IN, ERROR_N_IN}),
    .q(stat_sync)
  );
  ppl_sync #(.W(8)) u_bus_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .d(PRINTER_DATA_BUS_I),
    .q(bus_sync)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_data_out = data_out;
    next_data_in = data_in;
    next_status = 8'h00;
    if (CTRL_WE) begin
      next_ctrl = CTRL_WDATA;
    end
    if (DATA_WE) begin
      next_data_out = DATA_WDATA;
    end
    // input mode samples the synchronised bus
    if (PORT_SELECT && DIR_INPUT) begin
      next_data_in = bus_sync;
    end
    next_status[ppl_pkg::STAT_ERROR] = stat_sync[0];
    next_status[ppl_pkg::STAT_SELECTED] = stat_sync[1];
    next_status[ppl_pkg::STAT_PAPER_OUT] = stat_sync[2];
    next_status[ppl_pkg::STAT_ACK] = stat_sync[3];
    next_status[ppl_pkg::STAT_BUSY] = stat_sync[4];
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= ppl_pkg::CTRL_RESET;
      data_out <= ppl_pkg::DATA_RESET;
      data_in <= ppl_pkg::DATA_RESET;
      status <= 8'h00;
    end else if (CE) begin
      ctrl <= next_ctrl;
      data_out <= next_data_out;
      data_in <= next_data_in;
      status <= next_status;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // pin levels come straight from the control flops, no extra stage
  assign PRINTER_SELECT_OUT_N = ~ctrl[ppl_pkg::CTRL_SELECT];
  assign INIT_N = ctrl[ppl_pkg::CTRL_INIT];
  assign AUTO_LINEFEED_N = ~ctrl[ppl_pkg::CTRL_AUTOLF];
  assign DATA_STROBE_N = ~ctrl[ppl_pkg::CTRL_STROBE];
  assign drive_bus = PORT_SELECT && !DIR_INPUT;
  assign PRINTER_DATA_BUS_OE = {8{drive_bus}};
  assign PRINTER_DATA_BUS_O = data_out;
  assign CTRL_RDATA = ctrl;
  assign STATUS_RDATA = status;
  assign DATA_RDATA = data_in;

  // ----------------------------------------
  // settle counter for the status checks
  // ----------------------------------------
  // sync stages leave reset at zero while idle pins sit high, so status is
  // only trusted once the counter has saturated
  logic [3:0] settle_cnt, next_settle_cnt;
  logic settled;

  always_comb begin
    next_settle_cnt = settle_cnt;
    if (!(&settle_cnt)) begin
      next_settle_cnt = settle_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      settle_cnt <= '0;
    end else if (CE) begin
      settle_cnt <= next_settle_cnt;
    end
  end

  assign settled = &settle_cnt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------
  // control pins
  // ----------------------------------------
  a_select_pin_inv: assert property (
    PRINTER_SELECT_OUT_N == !ctrl[ppl_pkg::CTRL_SELECT])
    else $error("select pin not inverse of control bit");
  a_init_pin_level: assert property (
    INIT_N == ctrl[ppl_pkg::CTRL_INIT])
    else $error("init pin not equal to control bit");
  a_autolf_pin_level: assert property (
    AUTO_LINEFEED_N == !ctrl[ppl_pkg::CTRL_AUTOLF])
    else $error("line-feed pin not inverse of control bit");
  a_strobe_pin_level: assert property (
    DATA_STROBE_N == !ctrl[ppl_pkg::CTRL_STROBE])
    else $error("strobe pin not inverse of control bit");
  a_init_pin_follow: assert property (CE && CTRL_WE |=>
    INIT_N == $past(CTRL_WDATA[ppl_pkg::CTRL_INIT]))
    else $error("init pin does not follow written bit");
  a_autolf_pin_inv: assert property (CE && CTRL_WE |=>
    AUTO_LINEFEED_N != $past(CTRL_WDATA[ppl_pkg::CTRL_AUTOLF]))
    else $error("line-feed pin not inverse of written bit");
  sequence s_strobe_set;
    CE && CTRL_WE && CTRL_WDATA[ppl_pkg::CTRL_STROBE];
  endsequence
  sequence s_strobe_clear;
    CE && CTRL_WE && !CTRL_WDATA[ppl_pkg::CTRL_STROBE];
  endsequence
  a_strobe_pulse_low: assert property (s_strobe_set |=> !DATA_STROBE_N)
    else $error("strobe not low after bit set");
  a_strobe_release: assert property (s_strobe_clear |=> DATA_STROBE_N)
    else $error("strobe not high after bit cleared");
  a_ctrl_read_back: assert property (CE && CTRL_WE |=>
    CTRL_RDATA == $past(CTRL_WDATA))
    else $error("control read-back differs from write");
  // a frozen clock enable must hold the control register
  a_ce_freeze_ctrl: assert property (!CE |=> CTRL_RDATA == $past(CTRL_RDATA))
    else $error("control register moved with enable low");

  // ----------------------------------------
  // status mapping
  // ----------------------------------------
  // five steady samples cover three sync flops, the agree stage and the register
  sequence s_pin_steady(sig);
    settled && CE && $stable(sig) [*5];
  endsequence
  a_error_status_map: assert property (s_pin_steady(ERROR_N_IN) |->
    STATUS_RDATA[ppl_pkg::STAT_ERROR] == ERROR_N_IN)
    else $error("error status bit wrong");
  a_sel_status_map: assert property (s_pin_steady(PRINTER_SELECTED_IN) |->
    STATUS_RDATA[ppl_pkg::STAT_SELECTED] == PRINTER_SELECTED_IN)
    else $error("selected status bit wrong");
  a_paper_status_map: assert property (s_pin_steady(PAPER_OUT_IN) |->
    STATUS_RDATA[ppl_pkg::STAT_PAPER_OUT] == PAPER_OUT_IN)
    else $error("paper status bit wrong");
  a_ack_status_map: assert property (s_pin_steady(ACK_N_IN) |->
    STATUS_RDATA[ppl_pkg::STAT_ACK] == ACK_N_IN)
    else $error("ack status bit wrong");
  a_status_low_zero: assert property (
    STATUS_RDATA[ppl_pkg::STAT_ERROR-1:0] == '0)
    else $error("unused status bits not zero");

  // ----------------------------------------
  // data bus and busy status
  // ----------------------------------------
  a_bus_release_input: assert property (PORT_SELECT && DIR_INPUT |->
    PRINTER_DATA_BUS_OE == 8'h00)
    else $error("bus driven in input mode");
  a_data_in_sample: assert property (CE && PORT_SELECT && DIR_INPUT |=>
    DATA_RDATA == $past(bus_sync))
    else $error("input byte not sampled");
  a_data_in_hold: assert property (!(PORT_SELECT && DIR_INPUT) |=>
    DATA_RDATA == $past(DATA_RDATA))
    else $error("input byte moved outside input mode");
  a_bus_release_desel: assert property (!PORT_SELECT |-> PRINTER_DATA_BUS_OE == 8'h00)
    else $error("bus driven while deselected");
  a_bus_drive_out: assert property (PORT_SELECT && !DIR_INPUT |-> PRINTER_DATA_BUS_OE == 8'hff
    && PRINTER_DATA_BUS_O == data_out)
    else $error("bus not driven from latch");
  a_busy_status_map: assert property (s_pin_steady(BUSY_IN) |->
    STATUS_RDATA[ppl_pkg::STAT_BUSY] == BUSY_IN)
    else $error("busy status bit wrong");
endmodule
`default_nettype wire

/* bench/ppl_printer.sv */
`timescale 1ns/1ps
`default_nettype none
module ppl_printer (
  input wire logic clk,
  input wire logic strobe_n,
  input wire logic no_paper,
  input wire logic fault,
  output logic busy,
  output logic ack_n,
  output logic selected,
  output logic paper_out,
  output logic error_n
);
  logic [4:0] cnt = 5'h00;
  initial busy = 1'h0;
  initial ack_n = 1'h1;
  // a low strobe while idle starts a long busy spell, ack near its end
  always @(posedge clk) begin
    if (!busy) begin
      busy <= !strobe_n;
      cnt <= 5'h10;
      ack_n <= 1'h1;
    end else begin
      cnt <= cnt - 5'h01;
      ack_n <= cnt > 5'h04;
      busy <= cnt != 5'h00;
    end
  end
  assign selected = 1'h1;
  assign paper_out = no_paper;
  assign error_n = !fault;
endmodule
`default_nettype wire

/* bench/printer_port_pin_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
module printer_port_pin_logic_test;
  logic clk = 0, rst = 1, sel = 0, dir = 0, cwe = 0, dwe = 0, no_paper = 0, fault = 0;
  logic ce = 1;
  logic [7:0] cwd = 8'h00, dwd = 8'h00, feed = 8'h00, crd, srd, drd, bo, boe;
  logic seln, initn, lfn, stbn, busy, ackn, slctd, pout, errn;
  int error_cnt = 0, checks = 0;
  ppl_port i_dut (.CLK(clk), .SYS_RST(rst), .CE(ce), .PORT_SELECT(sel), .DIR_INPUT(dir),
    .CTRL_WE(cwe), .CTRL_WDATA(cwd), .DATA_WE(dwe), .DATA_WDATA(dwd), .CTRL_RDATA(crd),
    .STATUS_RDATA(srd), .DATA_RDATA(drd), .PRINTER_SELECT_OUT_N(seln), .INIT_N(initn),
    .AUTO_LINEFEED_N(lfn), .DATA_STROBE_N(stbn), .PRINTER_SELECTED_IN(slctd),
    .PAPER_OUT_IN(pout), .BUSY_IN(busy), .ACK_N_IN(ackn), .ERROR_N_IN(errn),
    .PRINTER_DATA_BUS_I((bo & boe) | (feed & ~boe)), .PRINTER_DATA_BUS_O(bo),
    .PRINTER_DATA_BUS_OE(boe));
  ppl_printer i_prn (.clk(clk), .strobe_n(stbn), .no_paper(no_paper), .fault(fault),
    .busy(busy), .ack_n(ackn), .selected(slctd), .paper_out(pout), .error_n(errn));
  initial forever #20 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    cwd = v;
    cwe = 1;
    step(1);
    cwe = 0;
  endtask
  task automatic give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 16; i++) begin
      wr_ctrl(i[7:0]);
      chk("pins", {4'h0, seln, initn, lfn, stbn}, {4'h0, ~i[3], i[2], ~i[1], ~i[0]});
      chk("ctrl rd", crd, i[7:0]);
    end
    wr_ctrl(8'h00);
    // enable low must swallow the write
    ce = 0;
    wr_ctrl(8'h0F);
    chk("frozen rd", crd, 8'h00);
    chk("frozen pins", {4'h0, seln, initn, lfn, stbn}, 8'h0B);
    ce = 1;
    step(30);
  endtask
  // status lags the pins by five cycles
  task automatic t_hshake;
    wr_ctrl(8'h01);
    wr_ctrl(8'h00);
    step(8);
    chk("busy ack", {6'h00, srd[7:6]}, 8'h03);
    step(11);
    chk("busy ack", {6'h00, srd[7:6]}, 8'h02);
    step(12);
    chk("busy ack", {6'h00, srd[7:6]}, 8'h01);
  endtask
  task automatic t_status;
    no_paper = 1;
    fault = 1;
    step(6);
    chk("status", srd, 8'h70);
    no_paper = 0;
    fault = 0;
    step(6);
    chk("status", srd, 8'h58);
  endtask
  task automatic t_bus;
    chk("oe idle", boe, 8'h00);
    sel = 1;
    dwd = 8'hA5;
    dwe = 1;
    step(1);
    dwe = 0;
    chk("oe out", boe, 8'hFF);
    chk("bus out", bo, 8'hA5);
    dir = 1;
    feed = 8'h3C;
    step(6);
    chk("oe in", boe, 8'h00);
    chk("bus in", drd, 8'h3C);
    sel = 0;
    dir = 0;
    step(1);
    chk("oe off", boe, 8'h00);
  endtask
  initial begin
    step(16);
    chk("reset pins", {4'h0, seln, initn, lfn, stbn}, 8'h0B);
    rst = 0;
    step(1);
    t_ctrl;
    t_hshake;
    t_status;
    t_bus;
    give_verdict;
  end
  initial begin
    #20000;
    error_cnt++;
    give_verdict;
  end
endmodule
`default_nettype wire
